//--- include/rss_map.svh
// register offsets, flag positions and timing figures of the reset sequencer
// assumes a 20 MHz system clock and a byte-addressed wishbone register window
`ifndef RSS_MAP_SVH
`define RSS_MAP_SVH
`define RSS_CAUSE_OFF      8'h00
`define RSS_CTRL_OFF       8'h04
`define RSS_STAT_OFF       8'h08
`define RSS_BIT_POR        0
`define RSS_BIT_PIN        1
`define RSS_BIT_BOD        2
`define RSS_BIT_WDT        3
`define RSS_BIT_SCAN       4
`define RSS_CAUSE_RST      8'h01
`define RSS_CLK_KHZ        20000
`define RSS_BOD_MIN_NS     2000
`define RSS_PIN_MIN_NS     1500
`define RSS_TOUT_CYC       65536
`define RSS_CTRL_WDT_EN    0
`define RSS_CTRL_SCAN      1
`endif

//--- include/rss_pkg.sv
// types shared by the reset sequencer
// assumes rss_map.svh supplies the numeric constants
package rss_pkg;
    typedef logic [7:0] rss_byte_t;
    typedef enum logic [1:0] {
        RSS_HOLD = 2'b00,
        RSS_WAIT = 2'b01,
        RSS_RUN  = 2'b11
    } rss_state_e;
endpackage : rss_pkg

//--- verilog/rss_reset_sequencer.sv
// reset source combiner, start-up delay counter and reset-cause register
// assumes detector and pin inputs already synchronous to sys_clk_i
//
// The Wishbone slave port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`include "rss_map.svh"
module rss_reset_sequencer #(
    parameter int TOUT_CYC = `RSS_TOUT_CYC   // startup_timeout_period in cycles
) (
    input  wire logic          sys_clk_i,            // system clock
    input  wire logic          rst_i,                // sync reset, high
    input  wire logic          por_low_i,            // supply below poweron_threshold
    input  wire logic          rst_pin_n_i,          // external reset pin, low active
    input  wire logic          bod_low_i,            // supply below brownout_threshold
    input  wire logic          brownout_enable_fuse_i, // 1 = programmed
    input  wire logic          brownout_level_fuse_i,  // 1 = programmed
    input  wire logic          wdt_timeout_i,        // watchdog expiry pulse
    input  wire logic          scan_reset_i,         // scan reset register bit
    output logic               bod_level_hi_o,       // 1: 4.0V trigger, 0: 2.7V
    output logic               core_rst_o,           // reset to core, high
    input  wire logic          wb_cyc_i,             // wishbone cycle
    input  wire logic          wb_stb_i,             // wishbone strobe
    input  wire logic          wb_we_i,              // wishbone write
    input  wire logic [7:0]    wb_adr_i,             // byte address
    input  wire logic [3:0]    wb_sel_i,             // byte enables
    input  wire logic [31:0]   wb_dat_i,             // write data
    output logic [31:0]        wb_dat_o,             // read data
    output logic               wb_ack_o              // acknowledge
);
    import rss_pkg::*;

    // =========================================================
    // timing constants
    localparam int BOD_CYC = (`RSS_BOD_MIN_NS * `RSS_CLK_KHZ + 999999) / 1000000;
    localparam int PIN_CYC = (`RSS_PIN_MIN_NS * `RSS_CLK_KHZ + 999999) / 1000000;
    localparam int CW      = $clog2(TOUT_CYC + 1);

    // =========================================================
    // source filters
    logic [7:0]  bod_cnt_ff;
    logic [7:0]  pin_cnt_ff;
    logic        bod_det_ff;
    logic        pin_det_ff;
    logic        wdt_pulse_ff;
    logic        wdt_pulse_d_ff;
    logic        wdt_en_ff;
    logic        scan_sw_ff;
    logic        scan_rst;
    logic        bod_act;

    assign bod_level_hi_o = brownout_level_fuse_i;
    assign bod_act = brownout_enable_fuse_i & bod_low_i;

    always_ff @(posedge sys_clk_i) begin
        if (rst_i || !bod_act) begin
            bod_cnt_ff <= 8'h00;
            bod_det_ff <= 1'b0;
        end else if (bod_cnt_ff < 8'(BOD_CYC)) begin
            bod_cnt_ff <= bod_cnt_ff + 8'h01;
        end else begin
            bod_det_ff <= 1'b1;
        end
    end

    // pin width filter; pin is a level, held low keeps reset
    always_ff @(posedge sys_clk_i) begin
        if (rst_i || rst_pin_n_i) begin
            pin_cnt_ff <= 8'h00;
            pin_det_ff <= 1'b0;
        end else if (pin_cnt_ff < 8'(PIN_CYC)) begin
            pin_cnt_ff <= pin_cnt_ff + 8'h01;
        end else begin
            pin_det_ff <= 1'b1;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            wdt_pulse_ff   <= 1'b0;
            wdt_pulse_d_ff <= 1'b0;
        end else begin
            wdt_pulse_ff   <= wdt_timeout_i & wdt_en_ff & ~wdt_pulse_ff;
            wdt_pulse_d_ff <= wdt_pulse_ff;
        end
    end

    assign scan_rst = scan_reset_i | scan_sw_ff;

    // =========================================================
    // delay counter and sequencing
    rss_state_e  state_ff;
    logic [CW-1:0] tout_ff;
    logic        src_act;
    logic        wdt_fall;

    assign src_act  = pin_det_ff | bod_det_ff | scan_rst | wdt_pulse_ff;
    assign wdt_fall = wdt_pulse_d_ff & ~wdt_pulse_ff;

    // poweron holds; TOUT_CYC-cycle wait after drop
    always_ff @(posedge sys_clk_i) begin
        if (rst_i || por_low_i || src_act) begin
            state_ff <= RSS_HOLD;
            tout_ff  <= '0;
        end else begin
            unique case (state_ff)
                RSS_HOLD: begin
                    state_ff <= RSS_WAIT;
                    tout_ff  <= '0;
                end
                RSS_WAIT: begin
                    if (tout_ff >= CW'(TOUT_CYC - 1)) begin
                        state_ff <= RSS_RUN;
                    end
                    tout_ff <= tout_ff + CW'(1);
                end
                RSS_RUN: begin
                    if (wdt_fall) begin
                        state_ff <= RSS_WAIT;
                    end
                    tout_ff <= '0;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            core_rst_o <= 1'b1;
        end else begin
            core_rst_o <= por_low_i | src_act | (state_ff != RSS_RUN) | wdt_fall;
        end
    end

    // =========================================================
    // wishbone slave
    logic        req;
    logic        wr_cause;
    logic [4:0]  set_vec;
    rss_byte_t   cause_ff;

    assign req      = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wr_cause = req & wb_we_i & wb_sel_i[0] & (wb_adr_i == `RSS_CAUSE_OFF);

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= req;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            wdt_en_ff  <= 1'b0;
            scan_sw_ff <= 1'b0;
        end else if (req && wb_we_i && wb_sel_i[0] && wb_adr_i == `RSS_CTRL_OFF) begin
            wdt_en_ff  <= wb_dat_i[`RSS_CTRL_WDT_EN];
            scan_sw_ff <= wb_dat_i[`RSS_CTRL_SCAN];
        end
    end

    assign set_vec[`RSS_BIT_POR]  = por_low_i;
    assign set_vec[`RSS_BIT_PIN]  = pin_det_ff;
    assign set_vec[`RSS_BIT_BOD]  = bod_det_ff;
    assign set_vec[`RSS_BIT_WDT]  = wdt_pulse_ff;
    assign set_vec[`RSS_BIT_SCAN] = scan_rst;

    // set wins over a software clear in the same cycle
    // poweron clears others
    // poweron flag cleared by software only
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            cause_ff <= `RSS_CAUSE_RST;
        end else begin
            for (int i = 0; i < 5; i++) begin
                if (set_vec[i]) begin
                    cause_ff[i] <= 1'b1;
                end else if (i != `RSS_BIT_POR && por_low_i) begin
                    cause_ff[i] <= 1'b0;
                end else if (wr_cause && !wb_dat_i[i]) begin
                    cause_ff[i] <= 1'b0;
                end
            end
            cause_ff[7:5] <= 3'h0;
        end
    end

    // data from flip-flop; unmapped reads give zero
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (req) begin
            unique case (wb_adr_i)
                `RSS_CAUSE_OFF: wb_dat_o <= {24'h000000, cause_ff};
                `RSS_CTRL_OFF:  wb_dat_o <= {30'h0, scan_sw_ff, wdt_en_ff};
                `RSS_STAT_OFF:  wb_dat_o <= {28'h0, bod_level_hi_o, state_ff, core_rst_o};
                default:        wb_dat_o <= 32'h0000_0000;
            endcase
        end
    end
endmodule : rss_reset_sequencer

//--- tb/rss_seq_asserts.sv
// port checker for the reset sequencer
// assumes sources synchronous to sys_clk_i
`timescale 1ns/1ps
module rss_seq_asserts #(parameter int TOUT_CYC = 16) (
    input wire logic sys_clk_i, rst_i, por_low_i, rst_pin_n_i, scan_reset_i,
    input wire logic brownout_level_fuse_i, bod_level_hi_o, core_rst_o,
    input wire logic wb_cyc_i, wb_stb_i, wb_ack_o
);
    // ==========
    // properties
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);
    a_por_now: assert property (por_low_i |=> core_rst_o)
        else $error("supply low gave no reset");
    a_scan_hold: assert property (scan_reset_i |=> core_rst_o)
        else $error("scan bit gave no reset");
    a_level_sel: assert property (bod_level_hi_o == brownout_level_fuse_i)
        else $error("level output wrong");
    a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack late");
    a_ack_once: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack too long");
    a_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    a_rel_quiet: assert property ($fell(core_rst_o) |->
        $past(!por_low_i && rst_pin_n_i && !scan_reset_i))
        else $error("release with source active");
    a_tout_wait: assert property ($fell(core_rst_o) |->
        $past(!por_low_i && rst_pin_n_i && !scan_reset_i, 8))
        else $error("release too early");
endmodule : rss_seq_asserts
bind rss_reset_sequencer rss_seq_asserts #(.TOUT_CYC(TOUT_CYC)) i_chk (.sys_clk_i, .rst_i,
    .por_low_i, .rst_pin_n_i, .scan_reset_i, .brownout_level_fuse_i, .bod_level_hi_o,
    .core_rst_o, .wb_cyc_i, .wb_stb_i, .wb_ack_o);

//--- tb/rss_src_model.sv
// reset source model: detectors, pin, watchdog, scan bit
// assumes go_i is a one-cycle strobe with sel_i and len_i set
`timescale 1ns/1ps
module rss_src_model (
    input  wire logic       sys_clk_i, // clock
    input  wire logic       go_i,      // start event
    input  wire logic [2:0] sel_i,     // 0 por 1 pin 2 bod 3 wdt 4 scan
    input  wire logic [7:0] len_i,     // cycles active
    output logic            por_low_o, rst_pin_n_o, bod_low_o, wdt_timeout_o, scan_reset_o
);
    logic [7:0] cnt_ff = 8'h00;
    logic [2:0] sel_ff = 3'h0;
    logic       act;
    // ==========
    // event timing
    always @(posedge sys_clk_i) begin
        if (go_i) {cnt_ff, sel_ff} <= {len_i, sel_i};
        else if (act) cnt_ff <= cnt_ff - 8'h01;
    end
    assign act = cnt_ff != 8'h00;
    assign por_low_o     = act && sel_ff == 3'h0;
    assign rst_pin_n_o   = !(act && sel_ff == 3'h1);
    assign bod_low_o     = act && sel_ff == 3'h2;
    assign wdt_timeout_o = act && sel_ff == 3'h3;
    assign scan_reset_o  = act && sel_ff == 3'h4;
endmodule : rss_src_model

//--- tb/rss_reset_sequencer_tb.sv
// bench: each reset source, refusals, cause register over wishbone
// assumes rss_src_model drives the sources
`timescale 1ns/1ps
`include "rss_map.svh"
module rss_reset_sequencer_tb;
    logic clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, go = 0, en = 0, lv = 0;
    logic [7:0] adr = 0, len = 0;
    logic [2:0] sel = 0;
    logic [31:0] wd = 0, lf = 32'h7309233F, rd, expq[$];
    logic ack, crst, por, pin_n, brownout_detector, wdt, scn, lvo;
    int fail_count = 0, n_tests = 0;
    // sel, length, bod_fuse wdt_en, expected cause
    logic [31:0] tbl [9] = '{32'h00030001, 32'h01230002, 32'h01140000, 32'h022D0204,
        32'h021E0200, 32'h022D0000, 32'h03010108, 32'h03010000, 32'h04030010};
    always #25 clk = ~clk;
    rss_reset_sequencer #(.TOUT_CYC(16)) i_dut (.sys_clk_i(clk), .rst_i(rst), .por_low_i(por),
        .rst_pin_n_i(pin_n), .bod_low_i(brownout_detector), .brownout_enable_fuse_i(en),
        .brownout_level_fuse_i(lv), .wdt_timeout_i(wdt), .scan_reset_i(scn),
        .bod_level_hi_o(lvo), .core_rst_o(crst), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wd), .wb_dat_o(rd),
        .wb_ack_o(ack));
    rss_src_model i_src (.sys_clk_i(clk), .go_i(go), .sel_i(sel), .len_i(len),
        .por_low_o(por), .rst_pin_n_o(pin_n), .bod_low_o(brownout_detector), .wdt_timeout_o(wdt),
        .scan_reset_o(scn));
    // ==========
    // tasks
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        {cyc, stb, we, adr, wd} <= {2'b11, w, a, d};
        do @(posedge clk); while (ack !== 1'b1);
        {cyc, stb} <= 2'b00;
    endtask : wb
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        expq.push_back(e);
        wb(1'b0, a, 32'h0);
    endtask : rd_chk
    task automatic wait_rel;
        repeat (200) if (crst !== 1'b0) @(posedge clk);
        chk(32'(crst), 32'h0);
    endtask : wait_rel
    task automatic test_done;
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : test_done
    // read data arrives with ack
    always @(posedge clk) if (ack === 1'b1 && !we && expq.size() > 0) chk(rd, expq.pop_front());
    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        test_done();
    end
    // ==========
    // main sequence
    initial begin
        logic [31:0] t;
        repeat (8) @(posedge clk);
        rst <= 0;
        wait_rel();
        rd_chk(`RSS_CAUSE_OFF, 32'h01);
        wb(1'b1, `RSS_CAUSE_OFF, 32'h0);
        rd_chk(8'h0C, 32'h0);
        foreach (tbl[k]) begin
            t = tbl[k];
            lf = lfsr(lf);
            {en, lv} <= {t[9], lf[3]};
            wb(1'b1, `RSS_CTRL_OFF, {31'h0, t[8]});
            {go, sel, len} <= {1'b1, t[26:24], t[23:16]};
            @(posedge clk);
            go <= 0;
            repeat (t[23:16] + 8'h03) @(posedge clk);
            chk(32'(crst), 32'(t[7:0] != 8'h00));
            wait_rel();
            rd_chk(`RSS_CAUSE_OFF, {24'h0, t[7:0]});
            wb(1'b1, `RSS_CAUSE_OFF, lf);
            rd_chk(`RSS_CAUSE_OFF, {24'h0, t[7:0] & lf[7:0]});
            rd_chk(`RSS_STAT_OFF, {28'h0, lv, 3'b110});
            chk(32'(lvo), 32'(lv));
            wb(1'b1, `RSS_CAUSE_OFF, 32'h0);
        end
        test_done();
    end
endmodule : rss_reset_sequencer_tb
